//--- design/pfc_consts.svh
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// ========================================
// register offsets (byte addresses)
`define PFC_OFF_DATA_L   8'h00
`define PFC_OFF_DATA_H   8'h04
`define PFC_OFF_ADDR_L   8'h08
`define PFC_OFF_ADDR_H   8'h0c
`define PFC_OFF_CTRL     8'h10
`define PFC_OFF_KEY      8'h14
`define PFC_OFF_STATUS   8'h18
`define PFC_OFF_MASK     8'h1c

// ========================================
// control register bit positions
`define PFC_CTL_RD       0
`define PFC_CTL_WR       1
`define PFC_CTL_EN       2
`define PFC_CTL_ERR      3
`define PFC_CTL_FREE     4
`define PFC_CTL_LO       5
`define PFC_CTL_CFG      6

// ========================================
// values
`define PFC_KEY_FIRST    8'h55
`define PFC_KEY_SECOND   8'haa
`define PFC_BLANK        14'h3fff
`define PFC_LAST_LATCH   5'h1f
`define PFC_RESP_OKAY    2'h0
`define PFC_RESP_SLVERR  2'h2

// ========================================
// configuration space words (low 15 address bits)
`define PFC_CFG_UID_LAST 15'h0003
`define PFC_CFG_DEV_ID   15'h0005
`define PFC_CFG_REV_ID   15'h0006
`define PFC_CFG_WORD1    15'h0007
`define PFC_CFG_WORD2    15'h0008

// ========================================
// timing
`define PFC_CLK_PERIOD_NS 10
`define PFC_PROG_TIME_NS  2000
`define PFC_PROG_CYCLES   ((`PFC_PROG_TIME_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)

`endif

//--- design/pfc_pkg.sv
package pfc_pkg;
  typedef logic [13:0] pfc_word_t;
  typedef logic [14:0] pfc_addr_t;
  // bit order matches the control register bits 6..0
  typedef struct packed {
    logic cfgSel;
    logic latchOnly;
    logic eraseSel;
    logic seqErr;
    logic progEn;
    logic wrStart;
    logic rdStart;
  } pfc_ctrl_s;
  typedef struct packed {
    logic opError;
    logic opDone;
  } pfc_evt_s;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_TIMED, ST_COMMIT} pfc_seq_e;
  typedef enum logic [1:0] {UNL_IDLE, UNL_FIRST, UNL_ARMED} pfc_unlock_e;
endpackage

//--- design/pfc_program_flash_control.sv
// Operation
// - config_space_sel set steers accesses to ID/config words, clear to program flash
// - config space: 8000h-8003h read/write, 8005h-8008h read-only
// - read of an unlisted config address leaves the data pair all zero
// - data pair holds a 14-bit word; high register bits 7-6 read zero
// - address pair is 15 bits, high bit 7 reads one, resets to zero
// - latch_only set: write only loads a latch; clear: load then program row
// - latch_only is ignored while erase is selected
// - erase select makes next write a row erase; hardware clears it after
// - error flag set on any write-start attempt or bad/terminated sequence; a prog_enable abort here does not set it
// - prog_enable clear forbids every program and erase
// - write-start launches self-timed operation; cleared by hardware only
// - read-start loads data pair within one cycle; cleared by hardware only
// - keys 55h then AAh must precede the write-start set
// - unlock_key is write-only, reads zero, stores nothing
// - low five address bits pick the latch; writes stay inside the row
// - all latches return to blank after each write or erase, except a latch_only write
// - a broken unlock pattern starts neither latch load nor programming
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "pfc_consts.svh"

module pfc_program_flash_control #(
  parameter logic [13:0] DEV_ID_WORD = 14'h0123, // arbitrary value
  parameter logic [13:0] REV_ID_WORD = 14'h0001, // arbitrary value
  parameter logic [13:0] CFG_WORD_1  = 14'h3fff,
  parameter logic [13:0] CFG_WORD_2  = 14'h3fff
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             irq
);
  import pfc_pkg::*;

  function automatic logic regMapped(input logic [7:0] a);
    regMapped = (a == `PFC_OFF_DATA_L) || (a == `PFC_OFF_DATA_H) ||
                (a == `PFC_OFF_ADDR_L) || (a == `PFC_OFF_ADDR_H) ||
                (a == `PFC_OFF_CTRL)   || (a == `PFC_OFF_KEY)    ||
                (a == `PFC_OFF_STATUS) || (a == `PFC_OFF_MASK);
  endfunction

  // ========================================
  // bus slave, write side
  logic        awHave_q, wHave_q, awReady_q, wReady_q, bValid_q, wLane_q;
  logic [7:0]  awAddr_q, wData_q;
  logic [1:0]  bResp_q;
  wire         awTake = s_axi_awvalid && awReady_q;
  wire         wTake  = s_axi_wvalid && wReady_q;
  wire         regWr  = ce && awHave_q && wHave_q && !bValid_q;
  wire         laneWr = regWr && wLane_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHave_q  <= 1'b0;
      wHave_q   <= 1'b0;
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      bValid_q  <= 1'b0;
      bResp_q   <= `PFC_RESP_OKAY;
      awAddr_q  <= 8'h00;
      wData_q   <= 8'h00;
      wLane_q   <= 1'b0;
    end else if (ce) begin
      if (awTake) begin
        awHave_q  <= 1'b1;
        awAddr_q  <= s_axi_awaddr;
        awReady_q <= 1'b0;
      end
      if (wTake) begin
        wHave_q  <= 1'b1;
        wData_q  <= s_axi_wdata[7:0];
        wLane_q  <= s_axi_wstrb[0];
        wReady_q <= 1'b0;
      end
      if (regWr) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= regMapped(awAddr_q) ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
      end
      if (bValid_q && s_axi_bready) begin
        bValid_q  <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q  <= 1'b1;
      end
    end
  end

  wire hitDataL = laneWr && (awAddr_q == `PFC_OFF_DATA_L);
  wire hitDataH = laneWr && (awAddr_q == `PFC_OFF_DATA_H);
  wire hitAddrL = laneWr && (awAddr_q == `PFC_OFF_ADDR_L);
  wire hitAddrH = laneWr && (awAddr_q == `PFC_OFF_ADDR_H);
  wire hitCtl   = laneWr && (awAddr_q == `PFC_OFF_CTRL);
  wire hitKey   = laneWr && (awAddr_q == `PFC_OFF_KEY);
  wire hitMask  = laneWr && (awAddr_q == `PFC_OFF_MASK);

  // ========================================
  // programming registers
  pfc_ctrl_s   ctrl_q;
  pfc_seq_e    seq_q;
  pfc_unlock_e unlock_q;
  logic [7:0]  dataLow_q, addrLow_q;
  logic [5:0]  dataHigh_q;
  logic [6:0]  addrHigh_q;
  logic [1:0]  stat_q, mask_q;
  logic [11:0] cnt_q;
  logic [4:0]  idx_q;
  logic [9:0]  opRow_q;
  logic        opErase_q, opCfg_q;
  logic [3:0][13:0] userId_q;
  pfc_word_t   flashMem [0:32767];
  pfc_word_t   latchBus [0:31];

  wire pfc_addr_t flashAddr = {addrHigh_q, addrLow_q};
  wire pfc_word_t flashWord = {dataHigh_q, dataLow_q};
  wire idle       = (seq_q == ST_IDLE);
  wire uidAddr    = (flashAddr <= `PFC_CFG_UID_LAST);

  // the unlock detector only advances on back-to-back register writes
  wire pfc_unlock_e unlockD =
      (hitKey && wData_q == `PFC_KEY_FIRST) ? UNL_FIRST :
      (hitKey && wData_q == `PFC_KEY_SECOND && unlock_q == UNL_FIRST) ? UNL_ARMED :
      UNL_IDLE;

  // mode bits come from the written byte, as a bit set rewrites the whole register
  wire wrAttempt = hitCtl && wData_q[`PFC_CTL_WR];
  wire opErase   = wData_q[`PFC_CTL_FREE];
  wire opCfg     = wData_q[`PFC_CTL_CFG];
  wire opLatch   = wData_q[`PFC_CTL_LO] && !opErase;
  wire cfgBad    = opCfg && !uidAddr;
  wire startOk   = wrAttempt && idle && (unlock_q == UNL_ARMED) &&
                   wData_q[`PFC_CTL_EN] && !cfgBad;
  wire loadLatch = startOk && !opErase && !opCfg;
  wire rdAttempt = hitCtl && wData_q[`PFC_CTL_RD] && idle && !wrAttempt;
  wire abort     = !idle && !ctrl_q.progEn;
  wire cntZero   = (cnt_q == 12'h000);
  wire finish    = !abort && ((seq_q == ST_LOAD) ||
                   (seq_q == ST_TIMED && cntZero && opCfg_q) ||
                   (seq_q == ST_COMMIT && idx_q == `PFC_LAST_LATCH));
  wire clrLatches = finish && (seq_q != ST_LOAD);

  // config space read: identity and configuration words, zero elsewhere
  wire pfc_word_t cfgWord =
      uidAddr ? userId_q[flashAddr[1:0]] :
      (flashAddr == `PFC_CFG_DEV_ID) ? DEV_ID_WORD :
      (flashAddr == `PFC_CFG_REV_ID) ? REV_ID_WORD :
      (flashAddr == `PFC_CFG_WORD1)  ? CFG_WORD_1 :
      (flashAddr == `PFC_CFG_WORD2)  ? CFG_WORD_2 : 14'h0000;
  wire pfc_word_t rdWord = ctrl_q.cfgSel ? cfgWord : flashMem[flashAddr];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= UNL_IDLE;
    end else if (regWr) begin
      unlock_q <= unlockD;
    end
  end

  // ========================================
  // control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
    end else if (ce) begin
      if (hitCtl && idle) begin
        ctrl_q.cfgSel    <= wData_q[`PFC_CTL_CFG];
        ctrl_q.latchOnly <= wData_q[`PFC_CTL_LO];
        ctrl_q.eraseSel  <= wData_q[`PFC_CTL_FREE];
      end
      if (hitCtl) begin
        ctrl_q.progEn <= wData_q[`PFC_CTL_EN];
        ctrl_q.seqErr <= wData_q[`PFC_CTL_ERR];
      end
      if (finish) begin
        ctrl_q.seqErr  <= 1'b0;
        ctrl_q.wrStart <= 1'b0;
      end
      if (clrLatches) begin
        ctrl_q.eraseSel <= 1'b0;
      end
      if (abort) begin
        ctrl_q.wrStart <= 1'b0;
      end
      if (startOk) begin
        ctrl_q.wrStart <= 1'b1;
      end
      if (wrAttempt) begin
        ctrl_q.seqErr <= 1'b1;
      end
      ctrl_q.rdStart <= rdAttempt;
    end
  end

  // ========================================
  // operation sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q     <= ST_IDLE;
      cnt_q     <= 12'h000;
      idx_q     <= 5'h00;
      opRow_q   <= 10'h000;
      opErase_q <= 1'b0;
      opCfg_q   <= 1'b0;
    end else if (ce) begin
      if (abort) begin
        seq_q <= ST_IDLE;
      end else begin
        unique case (seq_q)
          ST_IDLE: begin
            if (startOk) begin
              seq_q     <= (opLatch && !opCfg) ? ST_LOAD : ST_TIMED;
              cnt_q     <= 12'(`PFC_PROG_CYCLES - 1);
              opRow_q   <= flashAddr[14:5];
              opErase_q <= opErase;
              opCfg_q   <= opCfg;
            end
          end
          ST_LOAD: begin
            seq_q <= ST_IDLE;
          end
          ST_TIMED: begin
            cnt_q <= cnt_q - 12'h001;
            if (cntZero) begin
              seq_q <= opCfg_q ? ST_IDLE : ST_COMMIT;
              idx_q <= 5'h00;
            end
          end
          ST_COMMIT: begin
            idx_q <= idx_q + 5'h01;
            if (idx_q == `PFC_LAST_LATCH) begin
              seq_q <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // flash array; contents are undefined until a row is erased or written
  always_ff @(posedge clk) begin
    if (ce && seq_q == ST_COMMIT && !abort) begin
      flashMem[{opRow_q, idx_q}] <= opErase_q ? `PFC_BLANK : latchBus[idx_q];
    end
  end

  // write latches
  for (genvar i = 0; i < 32; i++) begin : gLatch
    pfc_word_t word_q;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        word_q <= `PFC_BLANK;
      end else if (ce) begin
        if (clrLatches) begin
          word_q <= `PFC_BLANK;
        end else if (loadLatch && flashAddr[4:0] == 5'(i)) begin
          word_q <= flashWord;
        end
      end
    end
    assign latchBus[i] = word_q;
  end

  // user ID words are the only writable part of configuration space
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      userId_q <= {4{`PFC_BLANK}};
    end else if (ce && finish && opCfg_q) begin
      if (opErase_q) begin
        userId_q <= {4{`PFC_BLANK}};
      end else begin
        userId_q[flashAddr[1:0]] <= flashWord;
      end
    end
  end

  // ========================================
  // data and address registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataLow_q  <= 8'h00;
      dataHigh_q <= 6'h00;
      addrLow_q  <= 8'h00;
      addrHigh_q <= 7'h00;
    end else if (ce) begin
      if (ctrl_q.rdStart) begin
        {dataHigh_q, dataLow_q} <= rdWord;
      end else begin
        if (hitDataL && idle) dataLow_q <= wData_q;
        if (hitDataH && idle) dataHigh_q <= wData_q[5:0];
      end
      if (hitAddrL && idle) addrLow_q <= wData_q;
      if (hitAddrH && idle) addrHigh_q <= wData_q[6:0];
    end
  end

  // ========================================
  // interrupt status, mask and output
  pfc_evt_s  evt;
  logic      arReady_q, rValid_q;
  logic [7:0] rdAddr_q;
  wire       arTake     = ce && s_axi_arvalid && arReady_q;
  wire       statusRead = arTake && (s_axi_araddr == `PFC_OFF_STATUS);
  assign evt.opDone  = finish;
  assign evt.opError = abort || (wrAttempt && !startOk);
  wire [1:0] statD   = (statusRead ? 2'b00 : stat_q) | evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 2'b00;
      mask_q <= 2'b00;
      irq    <= 1'b0;
    end else if (ce) begin
      stat_q <= statD;
      irq    <= |(statD & mask_q);
      if (hitMask) mask_q <= wData_q[1:0];
    end
  end

  // ========================================
  // bus slave, read side
  wire [31:0] rdMux =
      (s_axi_araddr == `PFC_OFF_DATA_L) ? {24'h000000, dataLow_q} :
      (s_axi_araddr == `PFC_OFF_DATA_H) ? {26'h0000000, dataHigh_q} :
      (s_axi_araddr == `PFC_OFF_ADDR_L) ? {24'h000000, addrLow_q} :
      (s_axi_araddr == `PFC_OFF_ADDR_H) ? {24'h000000, 1'b1, addrHigh_q} :
      (s_axi_araddr == `PFC_OFF_CTRL)   ? {24'h000000, 1'b1, ctrl_q} :
      (s_axi_araddr == `PFC_OFF_STATUS) ? {30'h00000000, stat_q} :
      (s_axi_araddr == `PFC_OFF_MASK)   ? {30'h00000000, mask_q} : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arReady_q   <= 1'b1;
      rValid_q    <= 1'b0;
      rdAddr_q    <= 8'h00;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PFC_RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        arReady_q   <= 1'b0;
        rValid_q    <= 1'b1;
        rdAddr_q    <= s_axi_araddr;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= regMapped(s_axi_araddr) ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
      end
      if (rValid_q && s_axi_rready) begin
        rValid_q  <= 1'b0;
        arReady_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;

  // ========================================
  // checks
  a_start_needs_key: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    $rose(ctrl_q.wrStart) |-> $past(unlock_q) == UNL_ARMED)
    else $error("write started without the unlock pattern");
  a_attempt_sets_err: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    wrAttempt |=> ctrl_q.seqErr)
    else $error("error flag not set on write-start attempt");
  a_disable_aborts: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    (!idle && !ctrl_q.progEn) |=> idle && !ctrl_q.wrStart)
    else $error("operation continued with programming disabled");
  a_read_one_cycle: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    rdAttempt |=> ctrl_q.rdStart ##1 (!ctrl_q.rdStart && flashWord == $past(rdWord)))
    else $error("read did not load the data pair in one cycle");
  a_cfg_zero_read: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    (ctrl_q.rdStart && ctrl_q.cfgSel && flashAddr > `PFC_CFG_WORD2) |=> flashWord == 14'h0000)
    else $error("unlisted config read not zero");
  a_erase_sel_clear: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    (clrLatches && opErase_q) |=> !ctrl_q.eraseSel && latchBus[0] == `PFC_BLANK)
    else $error("erase select or latches not cleared at completion");
  a_latch_blank: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    clrLatches |=> latchBus[31] == `PFC_BLANK && latchBus[5] == `PFC_BLANK)
    else $error("latches not blank after operation");
  a_addr_high_bit: assert property (@(posedge clk) disable iff (!arst_n)
    (rValid_q && rdAddr_q == `PFC_OFF_ADDR_H) |-> s_axi_rdata[7])
    else $error("address high bit 7 not one");
  a_key_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (rValid_q && rdAddr_q == `PFC_OFF_KEY) |-> s_axi_rdata == 32'h00000000)
    else $error("unlock key readable");
  a_timed_length: assert property (@(posedge clk) disable iff (!arst_n || !ce)
    (startOk && !opLatch) |=> ctrl_q.wrStart [*8])
    else $error("write-start cleared too early");
endmodule

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;
  typedef struct packed {
    logic       w;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
    logic [1:0] rs;
  } pfc_row_s;
  logic        clk     = 1'b0;
  logic        arst_n  = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        arvalid = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        irq;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rs;
  logic [31:0] rv;
  logic [13:0] wv;
  pfc_row_s    rows[10];
  logic [13:0] cfgExp[10];
  logic [13:0] pExp[4];
  int          failures = 0;
  int          samplesChecked = 0;
  int          i;

  always #5 clk = ~clk;

  pfc_program_flash_control #(.DEV_ID_WORD(14'h0123), .REV_ID_WORD(14'h0001)) dut (
    .clk(clk), .arst_n(arst_n), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq(irq)
  );

  // ========================================
  // reporting
  task automatic final_report;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samplesChecked++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic tmo(input string nm);
    failures++;
    $display("MISMATCH %s expected response seen timeout", nm);
    final_report();
  endtask

  // ========================================
  // bus master: called right after a rising edge
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    logic b;
    int   n;
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h0, d};
    b = 1'b0;
    n = 0;
    while (!b) begin
      #1;
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
      if (n > 50) tmo("write");
    end
  endtask

  task automatic axr(input logic [7:0] a);
    logic ar;
    logic r;
    int   n;
    arvalid <= 1'b1;
    araddr  <= a;
    r = 1'b0;
    n = 0;
    while (!r) begin
      #1;
      ar = arvalid && arready;
      r = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      n++;
      if (n > 50) tmo("read");
    end
  endtask

  // ========================================
  // flash helpers
  task automatic prog(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c);
    axw(8'h08, a[7:0]);
    axw(8'h0c, {1'b0, a[14:8]});
    axw(8'h00, d[7:0]);
    axw(8'h04, {2'b00, d[13:8]});
    axw(8'h14, 8'h55);
    axw(8'h14, 8'haa);
    axw(8'h10, c);
  endtask

  task automatic rdword(input logic [14:0] a, input logic cfg);
    logic [7:0] lo;
    axw(8'h08, a[7:0]);
    axw(8'h0c, {1'b0, a[14:8]});
    axw(8'h10, {1'b0, cfg, 6'h05});
    repeat (2) @(posedge clk);
    axr(8'h00);
    lo = rv[7:0];
    axr(8'h04);
    wv = {rv[5:0], lo};
  endtask

  task automatic waitIdle;
    int n;
    for (n = 0; n < 300; n++) begin
      axr(8'h10);
      if (rv[1] === 1'b0) break;
    end
    if (n == 300) tmo("idle");
  endtask

  // ========================================
  // main sequence
  initial begin
    rows = '{'{1'b0, 8'h00, 8'h00, 8'h0c, 8'h80, 2'h0}, '{1'b0, 8'h00, 8'h00, 8'h08, 8'h00, 2'h0},
             '{1'b0, 8'h00, 8'h00, 8'h10, 8'h80, 2'h0}, '{1'b0, 8'h00, 8'h00, 8'h14, 8'h00, 2'h0},
             '{1'b1, 8'h04, 8'hff, 8'h04, 8'h3f, 2'h0}, '{1'b1, 8'h0c, 8'hff, 8'h0c, 8'hff, 2'h0},
             '{1'b1, 8'h14, 8'h55, 8'h14, 8'h00, 2'h0}, '{1'b1, 8'h10, 8'h78, 8'h10, 8'hf8, 2'h0},
             '{1'b1, 8'h10, 8'h04, 8'h10, 8'h84, 2'h0}, '{1'b1, 8'h20, 8'h11, 8'h20, 8'h00, 2'h2}};
    cfgExp = '{14'h3fff, 14'h3fff, 14'h3fff, 14'h3fff, 14'h0000,
               14'h0123, 14'h0001, 14'h3fff, 14'h3fff, 14'h0000};
    pExp = '{14'h3fff, 14'h1234, 14'h0abc, 14'h3fff};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++) begin
      if (rows[i].w) begin
        axw(rows[i].wa, rows[i].wd);
        chk("wresp", {30'h0, rows[i].rs}, {30'h0, rs});
      end
      axr(rows[i].ra);
      chk("regread", {24'h0, rows[i].ex}, rv);
      chk("rresp", {30'h0, rows[i].rs}, {30'h0, rs});
    end
    for (i = 0; i < 10; i++) begin
      rdword(15'(i), 1'b1);
      chk("cfgword", {18'h0, cfgExp[i]}, {18'h0, wv});
    end
    axr(8'h10);
    chk("rdclear", 32'hc4, rv);
    prog(15'h0021, 14'h1234, 8'h26);
    waitIdle();
    chk("latchload", 32'ha4, rv);
    prog(15'h0022, 14'h0abc, 8'h06);
    axw(8'h10, 8'h04);
    axr(8'h10);
    chk("busy", 32'h1, {31'h0, rv[1]});
    waitIdle();
    chk("rowdone", 32'h84, rv);
    for (i = 0; i < 4; i++) begin
      rdword(15'(32 + i), 1'b0);
      chk("flash", {18'h0, pExp[i]}, {18'h0, wv});
    end
    axr(8'h18);
    axw(8'h14, 8'h55);
    axw(8'h00, 8'h11);
    axw(8'h14, 8'haa);
    axw(8'h10, 8'h06);
    axr(8'h10);
    chk("brokenkey", 32'h8c, rv);
    #1;
    chk("irqmasked", 32'h0, {31'h0, irq});
    axr(8'h18);
    chk("status", 32'h2, rv);
    axw(8'h1c, 8'h03);
    prog(15'h0021, 14'h0000, 8'h02);
    axr(8'h10);
    chk("noenable", 32'h88, rv);
    #1;
    chk("irqset", 32'h1, {31'h0, irq});
    axr(8'h18);
    chk("status", 32'h2, rv);
    repeat (2) @(posedge clk);
    #1;
    chk("irqclear", 32'h0, {31'h0, irq});
    rdword(15'h0021, 1'b0);
    chk("keptword", 32'h1234, {18'h0, wv});
    prog(15'h0030, 14'h0000, 8'h36);
    waitIdle();
    chk("erasedone", 32'ha4, rv);
    rdword(15'h0021, 1'b0);
    chk("erased", 32'h3fff, {18'h0, wv});
    prog(15'h0002, 14'h0155, 8'h46);
    waitIdle();
    rdword(15'h0002, 1'b1);
    chk("userid", 32'h0155, {18'h0, wv});
    prog(15'h0006, 14'h0000, 8'h46);
    axr(8'h10);
    chk("roword", 32'hcc, rv);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    axr(8'h0c);
    chk("rstaddr", 32'h80, rv);
    final_report();
  end
endmodule
